// ==== verilog/terminal_io_conditioning.v ====
// terminal input/output conditioning with APB register access
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "terminal_io_defines.vh"
module terminal_io_conditioning
#(
  parameter integer NUM_INPUTS  = 5,
  parameter integer STEP_CYCLES = `RESP_STEP_CYCLES
)
(
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // terminal inputs, high while contact closed
  input  wire [4:0]  contact_closed,
  // drive status signals
  input  wire        running,
  input  wire        arrival_constant_speed,
  input  wire        arrival_over_frequency,
  input  wire        overload_notice,
  input  wire        pid_deviation,
  input  wire        alarm_signal,
  input  wire        arrival_set_frequency,
  input  wire        undervoltage_flag,
  input  wire        run_time_expired,
  input  wire        power_on_time_expired,
  input  wire        thermal_warning,
  input  wire        zero_speed_detect,
  input  wire        analog_disconnect_detect,
  input  wire        pid_second_stage,
  input  wire        network_disconnect_detect,
  input  wire        logic_operation_result,
  input  wire        starting_contact,
  input  wire        heatsink_overheat,
  input  wire        low_current_detect,
  input  wire        drive_ready,
  input  wire        forward_rotation,
  input  wire        reverse_rotation,
  input  wire        major_failure,
  input  wire        window_comparator,
  input  wire        frequency_source_indicator,
  input  wire        run_source_indicator,
  input  wire        second_motor_selected,
  // conditioned inputs to drive control
  output reg  [4:0]  input_active,
  // terminal outputs
  output reg         collector_conduct,
  output reg         relay_coil,
  // interrupt
  output reg         irq
);

  // ************************************************************
  // status selection
  // ************************************************************
  function sel_status;
    input [7:0]  code;
    input [31:0] st;
    begin
      case (code)
        8'h00: sel_status = st[0];
        8'h01: sel_status = st[1];
        8'h02: sel_status = st[2];
        8'h03: sel_status = st[3];
        8'h04: sel_status = st[4];
        8'h05: sel_status = st[5];
        8'h06: sel_status = st[6];
        8'h09: sel_status = st[7];
        8'h11: sel_status = st[8];
        8'h12: sel_status = st[9];
        8'h13: sel_status = st[10];
        8'h21: sel_status = st[11];
        8'h27: sel_status = st[12];
        8'h31: sel_status = st[13];
        8'h32: sel_status = st[14];
        8'h33: sel_status = st[15];
        8'h41: sel_status = st[16];
        8'h42: sel_status = st[17];
        8'h43: sel_status = st[18];
        8'h50: sel_status = st[19];
        8'h51: sel_status = st[20];
        8'h52: sel_status = st[21];
        8'h53: sel_status = st[22];
        8'h54: sel_status = st[23];
        8'h58: sel_status = st[24];
        8'h59: sel_status = st[25];
        8'h60: sel_status = st[26];
        default: sel_status = 1'b0;
      endcase
    end
  endfunction

  // response-time words sit in a run of five aligned slots
  function resp_hit;
    input [11:0] addr;
    begin
      resp_hit = (addr >= `REG_IN_RESP_0) && (addr < `REG_IN_RESP_0 + 12'h014) && (addr[1:0] == 2'b00);
    end
  endfunction

  function [2:0] resp_slot;
    input [11:0] addr;
    reg   [11:0] offs;
    begin
      offs      = addr - `REG_IN_RESP_0;
      resp_slot = offs[4:2];
    end
  endfunction

  wire [31:0] status_vec;
  assign status_vec = {5'h00, second_motor_selected, run_source_indicator, frequency_source_indicator,
                       window_comparator, major_failure, reverse_rotation, forward_rotation, drive_ready,
                       low_current_detect, heatsink_overheat, starting_contact, logic_operation_result,
                       network_disconnect_detect, pid_second_stage, analog_disconnect_detect,
                       zero_speed_detect, thermal_warning, power_on_time_expired, run_time_expired,
                       undervoltage_flag, arrival_set_frequency, alarm_signal, pid_deviation,
                       overload_notice, arrival_over_frequency, arrival_constant_speed, running};

  // ************************************************************
  // registers
  // ************************************************************
  reg  [4:0]  input_polarity_select;
  reg  [31:0] out_config;
  reg  [2:0]  reset_terminal;
  reg  [7:0]  input_response_time [0:NUM_INPUTS-1];
  reg  [4:0]  irq_status;
  reg  [4:0]  irq_mask;
  reg  [4:0]  raw_active;
  reg  [4:0]  prev_active;
  reg         filter_bypass;
  reg         event_arm;
  reg  [23:0] hold_cnt [0:NUM_INPUTS-1];
  reg  [7:0]  step_cnt [0:NUM_INPUTS-1];

  wire [7:0]  collector_output_function;
  wire [7:0]  relay_output_function;
  wire        collector_output_polarity;
  wire        relay_output_polarity;
  assign collector_output_function = out_config[`OC_COL_FUNC_LSB+7:`OC_COL_FUNC_LSB];
  assign relay_output_function     = out_config[`OC_REL_FUNC_LSB+7:`OC_REL_FUNC_LSB];
  assign collector_output_polarity = out_config[`OC_COL_POL_BIT];
  assign relay_output_polarity     = out_config[`OC_REL_POL_BIT];

  wire        wr_en;
  wire        rd_en;
  assign wr_en = psel & penable & pwrite & ~pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;

  // ************************************************************
  // input polarity
  // ************************************************************
  // one loop variable per process so none has two drivers
  integer i;
  integer j;
  integer k;
  always @*
  begin
    for (j = 0; j < 5; j = j + 1)
    begin
      if ((reset_terminal == j[2:0]) ||
          (input_polarity_select[j] == `POL_NORMALLY_OPEN))
        raw_active[j] = contact_closed[j];
      else
        raw_active[j] = ~contact_closed[j];
    end
  end

  // ************************************************************
  // response filter
  // ************************************************************
  // bypass lasts one cycle after reset so the first sample is taken unfiltered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      filter_bypass <= 1'b1;
    else
      filter_bypass <= 1'b0;
  end

  // first sample after reset is a load, not a change: keep it out of irq status
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_arm <= 1'b0;
    else
      event_arm <= ~filter_bypass;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_active <= 5'h00;
      for (i = 0; i < NUM_INPUTS; i = i + 1)
      begin
        hold_cnt[i] <= 24'h000000;
        step_cnt[i] <= 8'h00;
      end
    end
    else
    begin
      for (i = 0; i < NUM_INPUTS; i = i + 1)
      begin
        if (filter_bypass)
        begin
          input_active[i] <= raw_active[i];
          hold_cnt[i]     <= 24'h000000;
          step_cnt[i]     <= 8'h00;
        end
        else if (raw_active[i] == input_active[i])
        begin
          hold_cnt[i] <= 24'h000000;
          step_cnt[i] <= 8'h00;
        end
        else if (step_cnt[i] >= input_response_time[i])
        begin
          input_active[i] <= raw_active[i];
          hold_cnt[i]     <= 24'h000000;
          step_cnt[i]     <= 8'h00;
        end
        else if (hold_cnt[i] == STEP_CYCLES[23:0] - 24'h000001)
        begin
          hold_cnt[i] <= 24'h000000;
          step_cnt[i] <= step_cnt[i] + 8'h01;
        end
        else
          hold_cnt[i] <= hold_cnt[i] + 24'h000001;
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      collector_conduct <= 1'b0;
      relay_coil        <= 1'b0;
    end
    else
    begin
      collector_conduct <= sel_status(collector_output_function, status_vec) ^ collector_output_polarity;
      relay_coil        <= sel_status(relay_output_function, status_vec) ^ relay_output_polarity;
    end
  end

  // ************************************************************
  // apb and interrupts
  // ************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_polarity_select <= 5'h00;
      out_config            <= `RST_OUT_CONFIG;
      reset_terminal        <= `RST_RESET_TERM;
      irq_mask              <= 5'h00;
      irq_status            <= 5'h00;
      prev_active           <= 5'h00;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      prdata                <= 32'h00000000;
      irq                   <= 1'b0;
      for (k = 0; k < NUM_INPUTS; k = k + 1)
        input_response_time[k] <= `RST_RESP_TIME;
    end
    else
    begin
      pready      <= psel & penable & ~pready;
      pslverr     <= 1'b0;
      prev_active <= input_active;
      if (wr_en)
      begin
        case (paddr)
          `REG_IN_POLARITY: input_polarity_select <= pwdata[4:0];
          `REG_OUT_CONFIG:  out_config <= {14'h0000, pwdata[17:0]};
          `REG_RESET_TERM:  reset_terminal <= pwdata[2:0];
          `REG_IRQ_MASK:    irq_mask <= pwdata[4:0];
          `REG_IRQ_STATUS:  ;
          default:
          begin
            if (resp_hit(paddr))
            begin
              // clamp keeps the step count within the legal range
              if (pwdata[7:0] > `RESP_MAX)
                input_response_time[resp_slot(paddr)] <= `RESP_MAX;
              else
                input_response_time[resp_slot(paddr)] <= pwdata[7:0];
            end
            else
              pslverr <= 1'b1;
          end
        endcase
      end
      if (rd_en)
      begin
        case (paddr)
          `REG_IN_POLARITY: prdata <= {27'h0, input_polarity_select};
          `REG_OUT_CONFIG:  prdata <= out_config;
          `REG_RESET_TERM:  prdata <= {29'h0, reset_terminal};
          `REG_IN_STATE:    prdata <= {27'h0, input_active};
          `REG_STATUS_IN:   prdata <= status_vec;
          `REG_IRQ_STATUS:  prdata <= {27'h0, irq_status};
          `REG_IRQ_MASK:    prdata <= {27'h0, irq_mask};
          default:
          begin
            if (resp_hit(paddr))
              prdata <= {24'h0, input_response_time[resp_slot(paddr)]};
            else
            begin
              prdata  <= 32'h00000000;
              pslverr <= 1'b1;
            end
          end
        endcase
      end
      // set wins over write-one-to-clear
      irq_status <= (irq_status & ~((wr_en && paddr == `REG_IRQ_STATUS) ? pwdata[4:0] : 5'h00))
                    | ((input_active ^ prev_active) & {5{event_arm}});
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule
`default_nettype wire

// ==== verilog/terminal_io_defines.vh ====
// constants for the terminal input/output conditioning block
`ifndef TERMINAL_IO_DEFINES_VH
`define TERMINAL_IO_DEFINES_VH
// register byte offsets
`define REG_IN_POLARITY   12'h000
`define REG_OUT_CONFIG    12'h004
`define REG_RESET_TERM    12'h008
`define REG_IN_RESP_0     12'h00c
`define REG_IN_STATE      12'h020
`define REG_STATUS_IN     12'h024
`define REG_IRQ_STATUS    12'h028
`define REG_IRQ_MASK      12'h02c
// polarity encodings
`define POL_NORMALLY_OPEN   1'b0
`define POL_NORMALLY_CLOSED 1'b1
// output configuration fields
`define OC_COL_FUNC_LSB 0
`define OC_REL_FUNC_LSB 8
`define OC_COL_POL_BIT  16
`define OC_REL_POL_BIT  17
// reset values
`define RST_OUT_CONFIG  32'h0002_ffff
`define RST_RESP_TIME   8'h00
`define RST_RESET_TERM  3'h7
// function code for "no function"
`define FUNC_NONE       8'hff
// timing
`define RESP_STEP_NS    2000000
`define CLK_PERIOD_NS   50
`define RESP_STEP_CYCLES (`RESP_STEP_NS / `CLK_PERIOD_NS)
`define RESP_MAX        8'hc8
`endif

// ==== tb/io_checker_properties.sv ====
// assertion checker for the terminal conditioning block
`timescale 1ns/1ps
`default_nettype none
// ********************************
// apb and terminal output checks
// ********************************
module io_checker
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // terminal outputs
  input wire logic        collector_conduct,
  input wire logic        relay_coil
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && penable && !pready |=> pready) else $error("no answer in access");
  setup_wait_a: assert property (psel && !penable |=> !pready) else $error("answer without wait state");
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
  ready_after_a: assert property (pready |-> $past(psel && penable)) else $error("ready without access");
  pready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
  reset_outputs_a: assert property ($rose(presetn) |-> !relay_coil && !collector_conduct)
    else $error("outputs on at reset");
endmodule
bind terminal_io_conditioning io_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .collector_conduct(collector_conduct), .relay_coil(relay_coil));
`default_nettype wire

// ==== tb/terminal_partner.sv ====
// model of the external contacts and drive status lines
`timescale 1ns/1ps
`default_nettype none
// ********************************
// contact and status sources
// ********************************
module terminal_partner
(
  // clock
  input  wire logic        pclk,
  // terminal side
  output var  logic [4:0]  contact_closed,
  // status lines, one bit per code in table order
  output var  logic [26:0] status
);
  logic [4:0]  contact_req = 5'h00;
  logic [26:0] status_req  = 27'h0;
  // contacts and status lines move on a clock edge, one edge after a request
  always @(posedge pclk)
  begin
    contact_closed <= contact_req;
    status         <= status_req;
  end
  // called just after a rising edge so no change races the sample
  task set_contacts(input logic [4:0] v);
    contact_req <= v;
  endtask
  task set_status(input logic [26:0] v);
    status_req <= v;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_inverter_terminal_io_conditioning.sv ====
// testbench for the terminal conditioning block
`timescale 1ns/1ps
`default_nettype none
// ********************************
// bench, tasks and sequence
// ********************************
module tb_inverter_terminal_io_conditioning;
  // short step keeps filter runs brief
  localparam int STEP = 4;
  localparam logic [7:0] codes [27] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h11, 8'h12,
    8'h13, 8'h21, 8'h27, 8'h31, 8'h32, 8'h33, 8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h58, 8'h59, 8'h60};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic        err;
  wire  [31:0] prdata;
  wire         pready, pslverr, collector_conduct, relay_coil, irq;
  wire  [4:0]  contact_closed, input_active;
  wire  [26:0] st;
  int          error_cnt = 0;
  int          tests_run = 0;
  always #25 pclk = ~pclk;
  terminal_partner ptn_u (.pclk(pclk), .contact_closed(contact_closed), .status(st));
  terminal_io_conditioning #(.NUM_INPUTS(5), .STEP_CYCLES(STEP)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .contact_closed(contact_closed), .running(st[0]),
    .arrival_constant_speed(st[1]), .arrival_over_frequency(st[2]), .overload_notice(st[3]), .pid_deviation(st[4]),
    .alarm_signal(st[5]), .arrival_set_frequency(st[6]), .undervoltage_flag(st[7]), .run_time_expired(st[8]),
    .power_on_time_expired(st[9]), .thermal_warning(st[10]), .zero_speed_detect(st[11]),
    .analog_disconnect_detect(st[12]), .pid_second_stage(st[13]), .network_disconnect_detect(st[14]),
    .logic_operation_result(st[15]), .starting_contact(st[16]), .heatsink_overheat(st[17]),
    .low_current_detect(st[18]), .drive_ready(st[19]), .forward_rotation(st[20]), .reverse_rotation(st[21]),
    .major_failure(st[22]), .window_comparator(st[23]), .frequency_source_indicator(st[24]),
    .run_source_indicator(st[25]), .second_motor_selected(st[26]), .input_active(input_active),
    .collector_conduct(collector_conduct), .relay_coil(relay_coil), .irq(irq));
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #500000;
    error_cnt++;
    finish_test;
  end
  initial
  begin
    ptn_u.set_contacts(5'b10101);
    tick(3);
    chk("relay_in_reset", 32'h0, {31'h0, relay_coil});
    presetn <= 1'b1;
    tick(3);
    chk("active_after_reset", 32'h15, {27'h0, input_active});
    rd_chk(12'h028, 32'h0, "irq_after_reset");
    rd_chk(12'h000, 32'h0, "in_polarity");
    rd_chk(12'h004, 32'h0002ffff, "out_config");
    rd_chk(12'h008, 32'h7, "reset_term");
    apb(1'b1, 12'h000, 32'h0a);
    ptn_u.set_contacts(5'b00110);
    tick(3);
    chk("active_polarity", 32'h0c, {27'h0, input_active});
    rd_chk(12'h020, 32'h0c, "in_state");
    apb(1'b1, 12'h008, 32'h1);
    tick(3);
    chk("active_reset_term", 32'h0e, {27'h0, input_active});
    apb(1'b1, 12'h008, 32'h7);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h00c, 32'h3);
    // glitch shorter than 3 steps must vanish
    ptn_u.set_contacts(5'b00001);
    tick(5);
    ptn_u.set_contacts(5'b00000);
    tick(20);
    chk("glitch", 32'h0, {31'h0, input_active[0]});
    ptn_u.set_contacts(5'b00001);
    tick(6);
    chk("early", 32'h0, {31'h0, input_active[0]});
    tick(14);
    chk("settled", 32'h1, {31'h0, input_active[0]});
    apb(1'b1, 12'h00c, 32'hff);
    rd_chk(12'h00c, 32'hc8, "resp_clamp");
    rd_chk(12'h010, 32'h0, "resp_other");
    for (int i = 0; i < 27; i++)
    begin
      apb(1'b1, 12'h004, {16'h0, codes[i], codes[i]});
      ptn_u.set_status(27'h1 << i);
      tick(3);
      chk("col_on", 32'h1, {31'h0, collector_conduct});
      chk("rel_on", 32'h1, {31'h0, relay_coil});
      ptn_u.set_status(~(27'h1 << i));
      tick(3);
      chk("col_off", 32'h0, {31'h0, collector_conduct});
      chk("rel_off", 32'h0, {31'h0, relay_coil});
    end
    apb(1'b1, 12'h004, 32'h0000ffff);
    ptn_u.set_status(27'h7ffffff);
    tick(3);
    chk("col_none", 32'h0, {31'h0, collector_conduct});
    apb(1'b1, 12'h004, 32'h00030500);
    ptn_u.set_status(27'h1);
    tick(3);
    chk("col_nc_act", 32'h0, {31'h0, collector_conduct});
    chk("rel_nc_norm", 32'h1, {31'h0, relay_coil});
    ptn_u.set_status(27'h20);
    tick(3);
    chk("col_nc_idle", 32'h1, {31'h0, collector_conduct});
    chk("rel_nc_err", 32'h0, {31'h0, relay_coil});
    apb(1'b1, 12'h004, 32'h00000500);
    tick(3);
    chk("rel_no_err", 32'h1, {31'h0, relay_coil});
    apb(1'b1, 12'h02c, 32'h0);
    apb(1'b1, 12'h028, 32'h1f);
    rd_chk(12'h028, 32'h0, "irq_cleared");
    ptn_u.set_contacts(5'b01001);
    tick(3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd_chk(12'h028, 32'h08, "irq_status");
    apb(1'b1, 12'h02c, 32'h08);
    tick(3);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h028, 32'h08);
    tick(3);
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    ptn_u.set_contacts(5'b00010);
    presetn <= 1'b0;
    tick(3);
    chk("col_in_reset", 32'h0, {31'h0, collector_conduct});
    presetn <= 1'b1;
    tick(3);
    chk("active_rereset", 32'h02, {27'h0, input_active});
    finish_test;
  end
endmodule
`default_nettype wire
